/* File: src/art_timer.sv */
// auto-reload pwm timer top
`timescale 1ns/1ps
`include "art_consts.svh"
// Overview of operation
// - counter increments on each prescaler output tick.
// - counter_access_reg write loads counter live; count readable anytime.
// - overflow reloads counter from reload value; prescaler untouched.
// - 7-bit prescaler divides input by two to the select field.
// - input is cpu clock or external clock per source select.
// - run enable clear freezes prescaler and counter.
// - reset clears counter, prescaler, selects cpu clock; the source here follows ctrl.input_clock_source_select, not reset.
// - force reload with run, or counter write, inits counter and clears prescaler.
// - four shadow compares loaded from duty registers only at overflow.
// - each output enabled independently as push-pull drive.
// - pwm frequency is counter clock over 256 minus reload.
// - overflow sets the inverse of the polarity level; compare match restores the polarity level.
// - pwm generation stops while in halt.
// - overflow sets sticky flag; irq when enabled.
// - event mode flags overflow after 256 minus reload external events; the prescaler also divides them by two to the select field.
// - selected capture edge latches counter and sets capture flag, two channels.
// - per-channel edge select and capture irq enable.
// - capture register blocked until read; read clears flag.
// - capture irq held while flag and enable set.
// - captures act as edge interrupts and wake from halt.
// - overflow is transition from ff to reload value.
// - force reload reads as zero, acts on write of one.
// - reading status register clears overflow flag.
// - polarity zero high at or below compare; polarity change inverts at once.
module art_timer (
    input  wire logic                   ref_clk,
    input  wire logic                   arst_n,
    input  wire art_pkg::art_ctrl_type  ctrl,
    input  wire art_pkg::art_pwm_cfg_type pwm_cfg,
    input  wire art_pkg::art_cap_cfg_type cap_cfg,
    input  wire logic [31:0]            duty_cycle_reg_x,
    input  wire logic                   external_clock_in,
    input  wire logic [1:0]             capture_input_x,
    input  wire logic                   halt_mode,
    output logic [7:0]                  count_out,
    output logic [7:0]                  timer_control_status_reg,
    output logic                        overflow_flag,
    output logic                        overflow_irq,
    output logic [3:0]                  pulse_output_x,
    output logic [3:0]                  pulse_output_oe_x,
    output logic [1:0]                  capture_flag_x,
    output logic [15:0]                 capture_value_reg_x,
    output logic                        capture_irq,
    output logic                        wakeup
);
    art_pkg::art_core_state_type state;
    art_pkg::art_core_state_type next_state;
    logic                        in_tick;
    logic                        cnt_tick;
    logic [6:0]                  presc_inc;
    logic                        ovf_evt;
    logic [1:0]                  cap_flag;
    logic [15:0]                 cap_val;
    logic [3:0]                  pol_q;
    logic [3:0]                  lvl_next;
    logic [3:0]                  oe_q;
    logic                        irq_q;
    logic                        cirq_q;
    logic                        wake_q;
    logic [7:0]                  csr_q;

    // ************************************************************
    // input clock select and prescaler
    // ************************************************************
    always_comb begin
        // external clock treated as rising-edge event on synced pin
        in_tick = state.ext_sync[1] && !state.ext_prev;
        if (!ctrl.input_clock_source_select) begin
            in_tick = 1'b1;
        end
        if (!ctrl.counter_run_enable) begin
            in_tick = 1'b0;
        end
    end

    art_presc u_presc (
        .presc      (state.presc),
        .sel        (ctrl.clock_divider_select),
        .in_tick    (in_tick),
        .cnt_tick   (cnt_tick),
        .next_presc (presc_inc)
    );

    assign ovf_evt = cnt_tick && (state.count == `ART_CNT_MAX);

    // ************************************************************
    // counter, flags, shadows and pwm levels
    // ************************************************************
    always_comb begin
        next_state            = state;
        next_state.ext_sync   = {state.ext_sync[0], external_clock_in};
        next_state.ext_prev   = state.ext_sync[1];
        next_state.halt_sync0 = halt_mode;
        next_state.halt_sync1 = state.halt_sync0;
        next_state.presc      = presc_inc;
        next_state.raw_level  = lvl_next;
        if (cnt_tick) begin
            next_state.count = 8'(state.count + 8'h01);
        end
        if (ovf_evt) begin
            next_state.count  = ctrl.reload_value_reg;
            next_state.shadow = duty_cycle_reg_x;
        end
        if (ctrl.force_reload && ctrl.counter_run_enable) begin
            next_state.count = ctrl.reload_value_reg;
            next_state.presc = `ART_PRE_RESET;
        end
        if (ctrl.counter_access_wr) begin
            next_state.count = ctrl.counter_access_reg;
            next_state.presc = `ART_PRE_RESET;
        end
        if (ctrl.status_read) begin
            next_state.ovf_flag = 1'b0;
        end
        if (ovf_evt) begin
            next_state.ovf_flag = 1'b1;
        end
    end

    // halt freezes the waveform level in place
    generate
        for (genvar i = 0; i < `ART_NUM_PWM; i++) begin : g_pwm
            logic next_lvl;
            logic next_pin;
            always_comb begin
                next_lvl = state.raw_level[i];
                if (ovf_evt) begin
                    next_lvl = 1'b1;
                end else if (cnt_tick && state.count == state.shadow[8*i +: 8]) begin
                    next_lvl = 1'b0;
                end
                if (state.halt_sync1) begin
                    next_lvl = state.raw_level[i];
                end
                next_pin = next_lvl ^ pwm_cfg.output_polarity_x[i];
                next_pin = next_pin & pwm_cfg.output_enable_x[i];
            end
            assign lvl_next[i] = next_lvl;
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    pol_q[i] <= 1'b0;
                    oe_q[i]  <= 1'b0;
                end else begin
                    pol_q[i] <= next_pin;
                    oe_q[i]  <= pwm_cfg.output_enable_x[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state            <= '0;
            state.raw_level  <= 4'hF;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // input captures
    // ************************************************************
    generate
        for (genvar c = 0; c < `ART_NUM_CAP; c++) begin : g_cap
            art_capture u_cap (
                .ref_clk  (ref_clk),
                .arst_n   (arst_n),
                .pin      (capture_input_x[c]),
                .edge_sel (cap_cfg.capture_edge_select_x[c]),
                .rd       (cap_cfg.capture_read_x[c]),
                .count    (state.count),
                .flag     (cap_flag[c]),
                .value    (cap_val[8*c +: 8])
            );
        end
    endgenerate

    // ************************************************************
    // registered outputs
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q  <= 1'b0;
            cirq_q <= 1'b0;
            wake_q <= 1'b0;
            csr_q  <= `ART_REG_RESET;
        end else begin
            irq_q  <= next_state.ovf_flag && ctrl.overflow_irq_enable;
            cirq_q <= |(cap_flag & cap_cfg.capture_irq_enable_x);
            wake_q <= state.halt_sync1 && |(cap_flag & cap_cfg.capture_irq_enable_x);
            csr_q  <= {ctrl.input_clock_source_select, ctrl.clock_divider_select,
                       ctrl.counter_run_enable, 1'b0, ctrl.overflow_irq_enable,
                       next_state.ovf_flag};
        end
    end

    assign count_out                = state.count;
    assign overflow_flag            = state.ovf_flag;
    assign timer_control_status_reg = csr_q;
    assign overflow_irq             = irq_q;
    assign capture_irq              = cirq_q;
    assign wakeup                   = wake_q;
    assign capture_flag_x           = cap_flag;
    assign capture_value_reg_x      = cap_val;
    // disabled output drives nothing, pin left to port logic
    assign pulse_output_x           = pol_q;
    assign pulse_output_oe_x        = oe_q;

    // ************************************************************
    // checks
    // ************************************************************
    AST_OVF_RELOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ovf_evt && !ctrl.counter_access_wr && !ctrl.force_reload
        |=> state.count == $past(ctrl.reload_value_reg))
        else $error("no reload at overflow");
    AST_OVF_FLAG: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ovf_evt |=> state.ovf_flag)
        else $error("overflow flag not set");
    AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !ctrl.counter_run_enable && !ctrl.counter_access_wr
        |=> state.count == $past(state.count) && state.presc == $past(state.presc))
        else $error("counter moved while stopped");
    AST_CAR_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl.counter_access_wr |=> state.presc == 7'h00
        && state.count == $past(ctrl.counter_access_reg))
        else $error("counter write not applied");
    AST_SHADOW: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !ovf_evt |=> state.shadow == $past(state.shadow))
        else $error("shadow changed outside overflow");
    AST_CPU_TICK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl.counter_run_enable && !ctrl.input_clock_source_select
        && ctrl.clock_divider_select == 3'h0 && !ctrl.counter_access_wr
        && !ctrl.force_reload && state.count != 8'hFF
        |=> state.count == 8'($past(state.count) + 8'h01))
        else $error("divide by one not counting every cycle");
    AST_STATUS_CLR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl.status_read && !ovf_evt |=> !state.ovf_flag)
        else $error("status read did not clear flag");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state.ovf_flag && ctrl.overflow_irq_enable && $stable(ctrl.overflow_irq_enable)
        && !ctrl.status_read |=> overflow_irq)
        else $error("overflow irq missing");
    AST_FRL_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
        timer_control_status_reg[2] == 1'b0)
        else $error("force reload reads one");
    AST_OVF_STICKY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state.ovf_flag && !ctrl.status_read |=> state.ovf_flag)
        else $error("overflow flag lost without status read");
    AST_OVF_SOURCE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !state.ovf_flag && !ovf_evt |=> !state.ovf_flag)
        else $error("overflow flag set without overflow");
    AST_CNT_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !cnt_tick && !ctrl.counter_access_wr
        && !(ctrl.force_reload && ctrl.counter_run_enable)
        |=> state.count == $past(state.count))
        else $error("counter moved without a tick");
    AST_FRL_LOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl.force_reload && ctrl.counter_run_enable && !ctrl.counter_access_wr
        |=> state.presc == 7'h00 && state.count == $past(ctrl.reload_value_reg))
        else $error("force reload not applied");
    AST_EXT_GATE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl.input_clock_source_select && !(state.ext_sync[1] && !state.ext_prev)
        |-> !cnt_tick)
        else $error("tick without external edge");
    AST_CSR_LOW: assert property (@(posedge ref_clk) disable iff (!arst_n)
        1'b1 |=> timer_control_status_reg[1:0]
        == {$past(ctrl.overflow_irq_enable), state.ovf_flag})
        else $error("status bits do not follow flag and enable");
    AST_OVF_LEVEL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ovf_evt && !state.halt_sync1 |=> pulse_output_x
        == (~$past(pwm_cfg.output_polarity_x) & $past(pwm_cfg.output_enable_x)))
        else $error("pwm level wrong after overflow");
    AST_CMP_FALL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cnt_tick && !ovf_evt && !state.halt_sync1 && state.count == state.shadow[7:0]
        |=> !state.raw_level[0])
        else $error("compare match did not end the pulse");
    AST_OE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        1'b1 |=> pulse_output_oe_x == $past(pwm_cfg.output_enable_x))
        else $error("output enable not following its bit");
    AST_HALT_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state.halt_sync1 && $stable(pwm_cfg) |=> $stable(pulse_output_x))
        else $error("pwm moved during halt");
    AST_CIRQ_SET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        |(cap_flag & cap_cfg.capture_irq_enable_x) |=> capture_irq)
        else $error("capture irq missing");
    AST_CIRQ_CLR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !(|(cap_flag & cap_cfg.capture_irq_enable_x)) |=> !capture_irq)
        else $error("capture irq without enabled flag");
    AST_WAKE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state.halt_sync1 && |(cap_flag & cap_cfg.capture_irq_enable_x) |=> wakeup)
        else $error("no wakeup from capture in halt");
    AST_NO_WAKE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !state.halt_sync1 |=> !wakeup)
        else $error("wakeup outside halt");

    // ************************************************************
    // coverage
    // ************************************************************
    COV_OVF: cover property (@(posedge ref_clk) disable iff (!arst_n) ovf_evt);
    COV_CAP: cover property (@(posedge ref_clk) disable iff (!arst_n) |cap_flag);
    COV_EXT: cover property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl.input_clock_source_select && cnt_tick);
    COV_HALT: cover property (@(posedge ref_clk) disable iff (!arst_n) state.halt_sync1);
    COV_WAKE: cover property (@(posedge ref_clk) disable iff (!arst_n) wakeup);
endmodule

/* File: shared/art_consts.svh */
// constants for the auto-reload pwm timer
`ifndef ART_CONSTS_SVH
`define ART_CONSTS_SVH
`define ART_CNT_W        8
`define ART_PRE_W        7
`define ART_SEL_W        3
`define ART_NUM_PWM      4
`define ART_NUM_CAP      2
`define ART_CNT_MAX      8'hFF
`define ART_CNT_RESET    8'h00
`define ART_PRE_RESET    7'h00
`define ART_REG_RESET    8'h00
`endif

/* File: shared/art_pkg.sv */
// types for the auto-reload pwm timer
package art_pkg;
    typedef struct packed {
        logic [7:0] counter_access_reg;
        logic       counter_access_wr;
        logic [7:0] reload_value_reg;
        logic       input_clock_source_select;
        logic [2:0] clock_divider_select;
        logic       counter_run_enable;
        logic       force_reload;
        logic       overflow_irq_enable;
        logic       status_read;
    } art_ctrl_type;

    typedef struct packed {
        logic [3:0] output_enable_x;
        logic [3:0] output_polarity_x;
    } art_pwm_cfg_type;

    typedef struct packed {
        logic [1:0] capture_edge_select_x;
        logic [1:0] capture_irq_enable_x;
        logic [1:0] capture_read_x;
    } art_cap_cfg_type;

    typedef struct packed {
        logic [7:0]  count;
        logic [6:0]  presc;
        logic        ovf_flag;
        logic [31:0] shadow;
        logic [3:0]  raw_level;
        logic [1:0]  ext_sync;
        logic        ext_prev;
        logic        halt_sync0;
        logic        halt_sync1;
    } art_core_state_type;

    typedef struct packed {
        logic [1:0] sync;
        logic       prev;
        logic       flag;
        logic [7:0] value;
    } art_cap_state_type;
endpackage

/* File: src/art_presc.sv */
// prescaler tap selection and counter tick generation
`timescale 1ns/1ps
`include "art_consts.svh"
module art_presc (
    input  wire logic [6:0] presc,
    input  wire logic [2:0] sel,
    input  wire logic       in_tick,
    output logic            cnt_tick,
    output logic [6:0]      next_presc
);
    // ************************************************************
    // tick when all prescaler bits below the tap are ones
    // ************************************************************
    logic [7:0] mask;
    always_comb begin
        mask       = (8'h01 << sel) - 8'h01;
        cnt_tick   = in_tick && (({1'b0, presc} & mask) == mask);
        next_presc = in_tick ? 7'(presc + 7'h01) : presc;
    end
endmodule

/* File: src/art_capture.sv */
// one input capture channel
`timescale 1ns/1ps
`include "art_consts.svh"
module art_capture (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       pin,
    input  wire logic       edge_sel,
    input  wire logic       rd,
    input  wire logic [7:0] count,
    output logic            flag,
    output logic [7:0]      value
);
    art_pkg::art_cap_state_type state;
    art_pkg::art_cap_state_type next_state;
    logic                       hit;

    // ************************************************************
    // sync, edge detect, latch
    // ************************************************************
    always_comb begin
        next_state         = state;
        next_state.sync    = {state.sync[0], pin};
        next_state.prev    = state.sync[1];
        hit = edge_sel ? (state.sync[1] && !state.prev) : (!state.sync[1] && state.prev);
        if (rd) begin
            next_state.flag = 1'b0;
        end
        // a capture blocked while flag is up, even in the cycle of the read that clears it
        if (hit && !state.flag) begin
            next_state.flag  = 1'b1;
            next_state.value = count;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flag  = state.flag;
    assign value = state.value;

    AST_CAP_BLOCK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state.flag && !rd |=> state.value == $past(state.value))
        else $error("capture value changed while flag set");
endmodule

/* File: verification/art_pins_model.sv */
// pin-side model: external clock source, capture inputs, pwm observer
`timescale 1ns/1ps
module art_pins_model (
    input  wire logic [3:0] pulse_output_x,
    input  wire logic       ref_clk,
    output logic            external_clock_in,
    output logic [1:0]      capture_input_x
);
    // ********************************
    // pin drivers
    // ********************************
    initial begin
        external_clock_in = 1'b0;
        capture_input_x = 2'b00;
    end

    // each level held 4 cycles, so the 2-flop sync cannot miss it
    task automatic ext_events(input int n);
        repeat (n) begin
            external_clock_in = 1'b1;
            repeat (4) @(negedge ref_clk);
            external_clock_in = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
    endtask

    // waits out sync plus capture latency before returning
    task automatic cap_level(input int ch, input logic v);
        capture_input_x[ch] = v;
        repeat (6) @(negedge ref_clk);
    endtask

    // phase-free duty measure: high cycles over a whole period
    task automatic high_time(input int ch, input int n, output int h);
        h = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (pulse_output_x[ch] === 1'b1) begin
                h++;
            end
        end
    endtask
endmodule

/* File: verification/test_art_timer.sv */
// self-checking bench for the auto-reload pwm timer
`timescale 1ns/1ps
module test_art_timer;
    logic                     ref_clk = 1'b0;
    logic                     arst_n = 1'b0;
    art_pkg::art_ctrl_type    ctrl;
    art_pkg::art_pwm_cfg_type pcfg;
    art_pkg::art_cap_cfg_type ccfg;
    logic [31:0]              duty;
    logic                     halt;
    logic                     eclk;
    logic [1:0]               cin;
    logic [7:0]               cnt;
    logic [7:0]               csr;
    logic                     ovf;
    logic                     oirq;
    logic [3:0]               pwm;
    logic [3:0]               oe;
    logic [1:0]               cflag;
    logic [15:0]              cval;
    logic                     cirq;
    logic                     wake;
    logic [3:0]               held;
    int                       miscompares = 0;
    int                       comparisons = 0;
    int                       p;
    int                       h;
    int                       exp_h[4] = '{5, 7, 15, 5};

    always #50 ref_clk = ~ref_clk;

    art_timer i_art_timer (
        .ref_clk(ref_clk), .arst_n(arst_n), .ctrl(ctrl), .pwm_cfg(pcfg), .cap_cfg(ccfg),
        .duty_cycle_reg_x(duty), .external_clock_in(eclk), .capture_input_x(cin),
        .halt_mode(halt), .count_out(cnt), .timer_control_status_reg(csr),
        .overflow_flag(ovf), .overflow_irq(oirq), .pulse_output_x(pwm),
        .pulse_output_oe_x(oe), .capture_flag_x(cflag), .capture_value_reg_x(cval),
        .capture_irq(cirq), .wakeup(wake)
    );

    art_pins_model i_art_pins_model (
        .pulse_output_x(pwm), .ref_clk(ref_clk), .external_clock_in(eclk),
        .capture_input_x(cin)
    );

    // ********************************
    // shared tasks
    // ********************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wait_cnt(input logic [7:0] v);
        for (int i = 0; i < 3000 && cnt !== v; i++) begin
            cyc(1);
        end
        if (cnt !== v) begin
            chk("wait count", 16'(v), 16'(cnt));
            give_verdict();
        end
    endtask

    // 0 counter write, 1 force reload, else status read
    task automatic strobe(input int k);
        case (k)
            0: ctrl.counter_access_wr = 1'b1;
            1: ctrl.force_reload = 1'b1;
            default: ctrl.status_read = 1'b1;
        endcase
        cyc(1);
        case (k)
            0: ctrl.counter_access_wr = 1'b0;
            1: ctrl.force_reload = 1'b0;
            default: ctrl.status_read = 1'b0;
        endcase
    endtask

    // first interval may be short after a divider change, so time the second
    task automatic period(output int n);
        logic [7:0] c;
        for (int k = 0; k < 2; k++) begin
            c = cnt;
            n = 0;
            while (cnt === c && n < 300) begin
                cyc(1);
                n++;
            end
        end
    endtask

    task automatic cap_read(input logic [1:0] m);
        ccfg.capture_read_x = m;
        cyc(1);
        ccfg.capture_read_x = 2'b00;
        cyc(2);
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        ctrl = '0;
        pcfg = '0;
        ccfg = '0;
        duty = '0;
        halt = 1'b0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        chk("reset state", 16'h0000, {cnt, csr});
        chk("reset pins", 16'h0000, {8'h00, pwm, oe});
        $display("test reset done");

        ctrl.counter_access_reg = 8'h40;
        strobe(0);
        cyc(3);
        chk("count load", 16'h0040, 16'(cnt));
        ctrl.counter_run_enable = 1'b1;
        for (int d = 0; d < 8; d++) begin
            ctrl.clock_divider_select = d[2:0];
            period(p);
            chk("tick period", 16'(1 << d), 16'(p));
        end
        $display("test divider done");

        ctrl.clock_divider_select = 3'h0;
        ctrl.reload_value_reg = 8'hFC;
        ctrl.overflow_irq_enable = 1'b1;
        ctrl.counter_access_reg = 8'hF0;
        strobe(0);
        strobe(2);
        cyc(2);
        chk("flag idle", 16'h0000, 16'({ovf, oirq}));
        wait_cnt(8'hFF);
        cyc(1);
        chk("wrap", 16'h00FC, 16'(cnt));
        cyc(2);
        chk("flag irq", 16'h0003, 16'({ovf, oirq}));
        ctrl.counter_run_enable = 1'b0;
        cyc(2);
        held = cnt[3:0];
        strobe(1);
        cyc(10);
        chk("frozen", 16'(held), 16'(cnt[3:0]));
        chk("status", 16'h0003, 16'(csr));
        strobe(2);
        cyc(3);
        chk("status read", 16'h0008, 16'({csr, ovf, oirq}));
        $display("test overflow done");

        ctrl.input_clock_source_select = 1'b1;
        ctrl.reload_value_reg = 8'hFD;
        ctrl.counter_run_enable = 1'b1;
        strobe(1);
        cyc(3);
        chk("forced load", 16'h00FD, 16'(cnt));
        i_art_pins_model.ext_events(2);
        chk("two events", 16'h00FF, {7'h00, ovf, cnt});
        i_art_pins_model.ext_events(1);
        chk("three events", 16'h01FD, {7'h00, ovf, cnt});
        chk("status ext", 16'h008B, 16'(csr));
        ctrl.counter_run_enable = 1'b0;
        strobe(2);
        $display("test events done");

        ctrl.input_clock_source_select = 1'b0;
        ctrl.reload_value_reg = 8'hF0;
        duty = 32'hFAFEF8F4;
        pcfg = '{output_enable_x: 4'hF, output_polarity_x: 4'hA};
        ctrl.counter_run_enable = 1'b1;
        strobe(1);
        cyc(40);
        chk("oe", 16'h000F, 16'(oe));
        for (int c = 0; c < 4; c++) begin
            i_art_pins_model.high_time(c, 16, h);
            chk("duty", 16'(exp_h[c]), 16'(h));
        end
        duty[7:0] = 8'hF1;
        pcfg.output_polarity_x[0] = 1'b1;
        pcfg.output_enable_x[3] = 1'b0;
        cyc(40);
        i_art_pins_model.high_time(0, 16, h);
        chk("new duty", 16'd14, 16'(h));
        chk("ch3 off", 16'h0000, 16'({pwm[3], oe[3]}));
        halt = 1'b1;
        cyc(4);
        held = pwm;
        cyc(30);
        chk("halt", 16'(held), 16'(pwm));
        halt = 1'b0;
        $display("test pwm done");

        ctrl.counter_run_enable = 1'b0;
        ctrl.counter_access_reg = 8'h5A;
        strobe(0);
        ccfg.capture_edge_select_x = 2'b01;
        ccfg.capture_irq_enable_x = 2'b11;
        i_art_pins_model.cap_level(1, 1'b1);
        chk("wrong edge", 16'h0000, 16'({cflag, cirq}));
        i_art_pins_model.cap_level(0, 1'b1);
        chk("capture 0", 16'h035A, {6'h00, cflag[0], cirq, cval[7:0]});
        ctrl.counter_access_reg = 8'h33;
        strobe(0);
        i_art_pins_model.cap_level(0, 1'b0);
        i_art_pins_model.cap_level(0, 1'b1);
        chk("blocked", 16'h005A, 16'(cval[7:0]));
        cap_read(2'b01);
        chk("read clears", 16'h0000, 16'({cflag, cirq}));
        halt = 1'b1;
        i_art_pins_model.cap_level(1, 1'b0);
        chk("capture 1", 16'h0233, {6'h00, cflag, cval[15:8]});
        chk("wake", 16'h0003, 16'({cirq, wake}));
        ccfg.capture_irq_enable_x = 2'b00;
        cyc(3);
        chk("irq masked", 16'h0000, 16'({cirq, wake}));
        cap_read(2'b10);
        halt = 1'b0;
        chk("flag 1 clear", 16'h0000, 16'(cflag));
        $display("test capture done");
        give_verdict();
    end
endmodule
